// ---- inc/slsync_pkg.sv ----
// package for the lane sync request and pattern checker block
// assumes a byte-wide register port with 12-bit addresses on mclk
package slsync_pkg;
	localparam int LANES = 4;
	localparam int CNT_W = 24;
	localparam logic [11:0] ADDR_FIFO_EMPTY = 12'h30D;
	localparam logic [11:0] ADDR_SYNC_MASK = 12'h311;
	localparam logic [11:0] ADDR_SYNC_DUR = 12'h312;
	localparam logic [11:0] ADDR_MF_PERIOD = 12'h313;
	localparam logic [11:0] ADDR_PHY_SETUP = 12'h314;
	localparam logic [11:0] ADDR_TEST_EN = 12'h315;
	localparam logic [11:0] ADDR_TEST_CTRL = 12'h316;
	localparam logic [11:0] ADDR_THR_LO = 12'h317;
	localparam logic [11:0] ADDR_THR_MID = 12'h318;
	localparam logic [11:0] ADDR_THR_HI = 12'h319;
	localparam logic [11:0] ADDR_CNT_LO = 12'h31A;
	localparam logic [11:0] ADDR_CNT_MID = 12'h31B;
	localparam logic [11:0] ADDR_CNT_HI = 12'h31C;
	localparam logic [11:0] ADDR_PASS = 12'h31D;
	localparam int FRAME_LOSS_BIT = 0;
	localparam int MF_LOSS_BIT = 2;
	localparam int RUN_BIT = 1;
	localparam int CLEAR_BIT = 0;
	localparam int SRC_LSB = 4;
	localparam int PAT_LSB = 2;
	// base sync low time: 5 frames + 9 octets, in parallel clocks (4 octets each), rounded up, plus one clock
	localparam int OCTETS_PER_PCLK = 4;
	localparam int BASE_OCTETS = 9;
	localparam logic [7:0] PASS_RESET = 8'h0F;
	localparam logic [7:0] BYTE_RESET = 8'h00;
	typedef enum logic [1:0] {PAT_P7, PAT_P15, PAT_P31, PAT_RSVD} slsync_pat_t;
	typedef struct packed {
		logic [11:0] addr;
		logic [7:0] wdata;
		logic wr;
	} slsync_wr_t;
endpackage : slsync_pkg

// ---- core/slsync_lane_check.sv ----
// one lane pattern checker: self-seeding prbs compare with saturating error count
// assumes one data bit per mclk per lane, already synchronised
`timescale 1ns/1ps
module slsync_lane_check #(
	parameter int CNT_W = 24
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic clear,
	input wire logic run,
	input wire logic [1:0] patSel,
	input wire logic rxBit,
	output logic [CNT_W-1:0] errCount
);
	logic [30:0] shift_q, shift_d;
	logic [CNT_W-1:0] cnt_q, cnt_d;
	logic refBit;

	always_comb begin
		case (slsync_pkg::slsync_pat_t'(patSel))
			slsync_pkg::PAT_P7: refBit = shift_q[6] ^ shift_q[5];
			slsync_pkg::PAT_P15: refBit = shift_q[14] ^ shift_q[13];
			slsync_pkg::PAT_P31: refBit = shift_q[30] ^ shift_q[27];
			default: refBit = rxBit;
		endcase
		shift_d = shift_q;
		cnt_d = cnt_q;
		if (clear) begin
			shift_d = '0;
			cnt_d = '0;
		end else if (run) begin
			// received bit reseeds the register so the check locks on its own
			shift_d = {shift_q[29:0], rxBit};
			if (rxBit != refBit && cnt_q != {CNT_W{1'b1}}) begin
				cnt_d = cnt_q + 1'b1;
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			shift_q <= '0;
			cnt_q <= '0;
		end else begin
			shift_q <= shift_d;
			cnt_q <= cnt_d;
		end
	end

	assign errCount = cnt_q;

	count_saturates_a: assert property (@(posedge mclk) disable iff (!rst_n)
		(cnt_q == {CNT_W{1'b1}} && !clear) |=> cnt_q == {CNT_W{1'b1}})
		else $error("error count wrapped");
	clear_holds_a: assert property (@(posedge mclk) disable iff (!rst_n)
		clear |=> cnt_q == '0)
		else $error("error count not cleared");
endmodule : slsync_lane_check

// ---- core/slsync_core.sv ----
// lane sync request generation, fifo empty report and per-lane pattern checker
// assumes lane inputs come from another clock and pass two flops; byte register port on mclk
`timescale 1ns/1ps
// Notes on behaviour
// - each bit of the fifo empty status is high while that logical lane's fifo is empty.
// - with the multiframe mask bit set, multiframe loss pulls the sync request low, else not.
// - with the frame mask bit set, frame loss pulls the sync request low, else not.
// - the request stays low over five frames plus nine octets at zero, one parallel clock more per step.
// - the multiframe period in parallel clocks is readable as an eight-bit status.
// - lane x's error test runs only while enable bit x is set.
// - the error count bytes show the lane picked by the source select field.
// - pattern select 00, 01, 10 give prbs7, prbs15, prbs31; 11 is reserved.
// - the test runs while the start bit is one and the clear bit is zero; it stops while either does not hold.
// - the 24-bit threshold is built from three writable bytes, low byte first.
// - the selected 24-bit count reads as three bytes, low byte at the lowest address.
// - each pass flag is one while its lane count is below threshold; they reset to one.
module slsync_core #(
	parameter int FRAME_OCTETS = 4,
	parameter int CNT_W = slsync_pkg::CNT_W
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [11:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [7:0] regRdata,
	input wire logic [3:0] fifoEmpty,
	input wire logic frameLoss,
	input wire logic multiframeLoss,
	input wire logic [7:0] multiframePeriodCycles,
	input wire logic [3:0] laneBits,
	output logic syncRequestOut_n,
	output logic [7:0] lanePhySetupValue
);
	localparam int BASE_CYC = (5 * FRAME_OCTETS + slsync_pkg::BASE_OCTETS + slsync_pkg::OCTETS_PER_PCLK - 1)
		/ slsync_pkg::OCTETS_PER_PCLK + 1;
	localparam int LANES = slsync_pkg::LANES;

	// ----------------------------------------------------------------
	// input synchronisers
	// ----------------------------------------------------------------
	logic [9:0] syncA_q, syncB_q;
	logic [3:0] emptyS, laneS;
	logic frameLossS, mfLossS;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			syncA_q <= '0;
			syncB_q <= '0;
		end else begin
			syncA_q <= {fifoEmpty, laneBits, frameLoss, multiframeLoss};
			syncB_q <= syncA_q;
		end
	end
	assign emptyS = syncB_q[9:6];
	assign laneS = syncB_q[5:2];
	assign frameLossS = syncB_q[1];
	assign mfLossS = syncB_q[0];

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	logic [7:0] mask_q, mask_d, dur_q, dur_d, setup_q, setup_d, ten_q, ten_d, ctrl_q, ctrl_d;
	logic [CNT_W-1:0] thr_q, thr_d;
	slsync_pkg::slsync_wr_t wr;

	assign wr = '{addr: regAddr, wdata: regWdata, wr: regWr};

	always_comb begin
		mask_d = mask_q;
		dur_d = dur_q;
		setup_d = setup_q;
		ten_d = ten_q;
		ctrl_d = ctrl_q;
		thr_d = thr_q;
		if (wr.wr) begin
			case (wr.addr)
				slsync_pkg::ADDR_SYNC_MASK: mask_d = wr.wdata & 8'h05;
				slsync_pkg::ADDR_SYNC_DUR: dur_d = wr.wdata;
				slsync_pkg::ADDR_PHY_SETUP: setup_d = wr.wdata;
				slsync_pkg::ADDR_TEST_EN: ten_d = wr.wdata & 8'h0F;
				slsync_pkg::ADDR_TEST_CTRL: ctrl_d = wr.wdata & 8'h7F;
				slsync_pkg::ADDR_THR_LO: thr_d[7:0] = wr.wdata;
				slsync_pkg::ADDR_THR_MID: thr_d[15:8] = wr.wdata;
				slsync_pkg::ADDR_THR_HI: thr_d[23:16] = wr.wdata;
				default: ;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			mask_q <= slsync_pkg::BYTE_RESET;
			dur_q <= slsync_pkg::BYTE_RESET;
			setup_q <= slsync_pkg::BYTE_RESET;
			ten_q <= slsync_pkg::BYTE_RESET;
			ctrl_q <= slsync_pkg::BYTE_RESET;
			thr_q <= '0;
		end else begin
			mask_q <= mask_d;
			dur_q <= dur_d;
			setup_q <= setup_d;
			ten_q <= ten_d;
			ctrl_q <= ctrl_d;
			thr_q <= thr_d;
		end
	end
	assign lanePhySetupValue = setup_q;

	// ----------------------------------------------------------------
	// pattern checkers
	// ----------------------------------------------------------------
	logic [CNT_W-1:0] laneCnt [LANES];
	logic [3:0] pass_q, pass_d;
	logic testClear, testRun;

	assign testClear = ctrl_q[slsync_pkg::CLEAR_BIT];
	assign testRun = ctrl_q[slsync_pkg::RUN_BIT] && !testClear;

	for (genvar i = 0; i < LANES; i++) begin : g_lane
		slsync_lane_check #(.CNT_W(CNT_W)) u_chk (
			.mclk(mclk),
			.rst_n(rst_n),
			.clear(testClear),
			.run(testRun && ten_q[i]),
			.patSel(ctrl_q[slsync_pkg::PAT_LSB +: 2]),
			.rxBit(laneS[i]),
			.errCount(laneCnt[i])
		);
		assign pass_d[i] = laneCnt[i] < thr_q;
	end

	// ----------------------------------------------------------------
	// sync request
	// ----------------------------------------------------------------
	typedef enum {SY_IDLE, SY_LOW} slsync_sy_t;
	slsync_sy_t sy_q, sy_d;
	logic [7:0] hold_q, hold_d;
	logic lossHit;
	logic sync_request_out_q, sync_request_out_d;

	assign lossHit = (mask_q[slsync_pkg::MF_LOSS_BIT] && mfLossS)
		|| (mask_q[slsync_pkg::FRAME_LOSS_BIT] && frameLossS);

	always_comb begin
		sy_d = sy_q;
		hold_d = hold_q;
		case (sy_q)
			SY_IDLE: begin
				if (lossHit) begin
					sy_d = SY_LOW;
					hold_d = 8'(BASE_CYC) + {4'h0, dur_q[3:0]};
				end
			end
			SY_LOW: begin
				if (hold_q > 8'h01) begin
					hold_d = hold_q - 8'h01;
				end else if (!lossHit) begin
					sy_d = SY_IDLE;
					hold_d = 8'h00;
				end
			end
			default: sy_d = SY_IDLE;
		endcase
		sync_request_out_d = (sy_d == SY_IDLE);
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sy_q <= SY_IDLE;
			hold_q <= 8'h00;
			sync_request_out_q <= 1'b1;
			pass_q <= slsync_pkg::PASS_RESET[3:0];
		end else begin
			sy_q <= sy_d;
			hold_q <= hold_d;
			sync_request_out_q <= sync_request_out_d;
			pass_q <= pass_d;
		end
	end
	assign syncRequestOut_n = sync_request_out_q;

	// ----------------------------------------------------------------
	// read data
	// ----------------------------------------------------------------
	logic [7:0] rd_q, rd_d;
	logic [CNT_W-1:0] selCnt;
	logic [2:0] srcSel;

	assign srcSel = ctrl_q[slsync_pkg::SRC_LSB +: 3];
	assign selCnt = (srcSel < 3'(LANES)) ? laneCnt[srcSel[1:0]] : '0;

	always_comb begin
		rd_d = rd_q;
		if (regRd) begin
			case (regAddr)
				slsync_pkg::ADDR_FIFO_EMPTY: rd_d = {4'h0, emptyS};
				slsync_pkg::ADDR_SYNC_MASK: rd_d = mask_q;
				slsync_pkg::ADDR_SYNC_DUR: rd_d = dur_q;
				slsync_pkg::ADDR_MF_PERIOD: rd_d = multiframePeriodCycles;
				slsync_pkg::ADDR_PHY_SETUP: rd_d = setup_q;
				slsync_pkg::ADDR_TEST_EN: rd_d = ten_q;
				slsync_pkg::ADDR_TEST_CTRL: rd_d = ctrl_q;
				slsync_pkg::ADDR_THR_LO: rd_d = thr_q[7:0];
				slsync_pkg::ADDR_THR_MID: rd_d = thr_q[15:8];
				slsync_pkg::ADDR_THR_HI: rd_d = thr_q[23:16];
				slsync_pkg::ADDR_CNT_LO: rd_d = selCnt[7:0];
				slsync_pkg::ADDR_CNT_MID: rd_d = selCnt[15:8];
				slsync_pkg::ADDR_CNT_HI: rd_d = selCnt[23:16];
				slsync_pkg::ADDR_PASS: rd_d = {4'h0, pass_q};
				default: rd_d = 8'h00;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rd_q <= 8'h00;
		end else begin
			rd_q <= rd_d;
		end
	end
	assign regRdata = rd_q;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	sequence lossSeen;
		sy_q == SY_IDLE && lossHit;
	endsequence
	sync_low_width_a: assert property (@(posedge mclk) disable iff (!rst_n)
		lossSeen |=> !syncRequestOut_n [*3])
		else $error("sync request too short");
	sync_masked_a: assert property (@(posedge mclk) disable iff (!rst_n)
		(sy_q == SY_IDLE && !lossHit) |=> syncRequestOut_n)
		else $error("sync request without unmasked loss");
	frame_mask_a: assert property (@(posedge mclk) disable iff (!rst_n)
		(sy_q == SY_IDLE && frameLossS && mask_q[0]) |=> !syncRequestOut_n)
		else $error("frame loss ignored");
	pass_flag_a: assert property (@(posedge mclk) disable iff (!rst_n)
		$past(rst_n) |-> pass_q[0] == $past(laneCnt[0] < thr_q))
		else $error("pass flag wrong");
	lane_idle_a: assert property (@(posedge mclk) disable iff (!rst_n)
		(!ten_q[1] && !testClear) |=> laneCnt[1] == $past(laneCnt[1]))
		else $error("disabled lane counted");
	stopped_test_a: assert property (@(posedge mclk) disable iff (!rst_n)
		(!ctrl_q[1] && !testClear) |=> $stable(laneCnt[0]))
		else $error("stopped test counted");
	count_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
		(regRd && regAddr == slsync_pkg::ADDR_CNT_LO) |=> regRdata == $past(selCnt[7:0]))
		else $error("count read wrong");
	empty_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
		(regRd && regAddr == slsync_pkg::ADDR_FIFO_EMPTY) |=> regRdata[7:4] == 4'h0)
		else $error("empty status reserved bits set");
	mf_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
		(regRd && regAddr == slsync_pkg::ADDR_MF_PERIOD) |=> regRdata == $past(multiframePeriodCycles))
		else $error("period read wrong");
	pass_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
		(regRd && regAddr == slsync_pkg::ADDR_PASS) |=> regRdata == {4'h0, $past(pass_q)})
		else $error("pass status read wrong");
	read_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
		!regRd |=> $stable(regRdata))
		else $error("read data moved without a read");
	thr_write_a: assert property (@(posedge mclk) disable iff (!rst_n)
		(regWr && regAddr == slsync_pkg::ADDR_THR_LO) |=> thr_q[7:0] == $past(regWdata))
		else $error("threshold low byte not written");
	src_range_a: assert property (@(posedge mclk) disable iff (!rst_n)
		(srcSel >= 3'(LANES)) |-> selCnt == '0)
		else $error("absent lane count not zero");
	mask_reserved_a: assert property (@(posedge mclk) disable iff (!rst_n)
		(mask_q & 8'hFA) == 8'h00)
		else $error("mask reserved bits set");
	enable_reserved_a: assert property (@(posedge mclk) disable iff (!rst_n)
		ten_q[7:4] == 4'h0)
		else $error("enable reserved bits set");
	ctrl_reserved_a: assert property (@(posedge mclk) disable iff (!rst_n)
		!ctrl_q[7])
		else $error("control reserved bit set");
	sync_held_a: assert property (@(posedge mclk) disable iff (!rst_n)
		(sy_q == SY_LOW && lossHit) |=> !syncRequestOut_n)
		else $error("sync request released during loss");
	hold_live_a: assert property (@(posedge mclk) disable iff (!rst_n)
		(sy_q == SY_LOW) |-> hold_q != 8'h00)
		else $error("hold counter empty while low");
	// five cycles is the shortest base width any frame size can give
	sequence lowHeld;
		!syncRequestOut_n [*5];
	endsequence
	sync_min_width_a: assert property (@(posedge mclk) disable iff (!rst_n)
		lossSeen |=> lowHeld)
		else $error("sync request below base width");
	for (genvar j = 0; j < LANES; j++) begin : g_lane_chk
		lane_pass_a: assert property (@(posedge mclk) disable iff (!rst_n)
			$past(rst_n) |-> pass_q[j] == $past(laneCnt[j] < thr_q))
			else $error("lane pass flag wrong");
		lane_off_a: assert property (@(posedge mclk) disable iff (!rst_n)
			(!ten_q[j] && !testClear) |=> $stable(laneCnt[j]))
			else $error("disabled lane counted");
		lane_clear_a: assert property (@(posedge mclk) disable iff (!rst_n)
			testClear |=> laneCnt[j] == '0)
			else $error("lane count not cleared");
	end
endmodule : slsync_core

// ---- verification/slsync_tx_model.sv ----
// far-side lane transmitter model: one pattern generator sent on all four lanes
// assumes mclk-rate bits, one per lane per cycle; flip inverts chosen lanes for one bit
`timescale 1ns/1ps
module slsync_tx_model (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [1:0] patSel,
	input wire logic [3:0] flip,
	output logic [3:0] laneBits
);
	// ----------------
	// pattern source
	// ----------------
	logic [30:0] sr_q;
	logic nb;
	always_comb begin
		case (patSel)
			2'h0: nb = sr_q[6] ^ sr_q[5];
			2'h1: nb = sr_q[14] ^ sr_q[13];
			default: nb = sr_q[30] ^ sr_q[27];
		endcase
	end
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sr_q <= 31'h7FFFFFFF;
			laneBits <= 4'h0;
		end else begin
			sr_q <= {sr_q[29:0], nb};
			laneBits <= {4{nb}} ^ flip;
		end
	end
endmodule : slsync_tx_model

// ---- verification/tb.sv ----
// self-checking bench for the lane sync and pattern checker core
// assumes the transmitter model drives laneBits; registers via the byte port
`timescale 1ns/1ps
module tb;
	logic mclk = 0, rst_n = 0, regWr = 0, regRd = 0, frameLoss = 0, multiframeLoss = 0, syncRequestOut_n;
	logic [11:0] regAddr = 12'h000;
	logic [7:0] regWdata = 8'h00, regRdata, mfp = 8'h00, setup, ctl = 8'h00, v;
	logic [3:0] fifoEmpty = 4'h0, laneBits, flip = 4'h0, fl;
	logic [1:0] pat = 2'h0;
	logic [23:0] a[4], b[4], thr;
	int err_count = 0, n_compared = 0, cyc = 0, w, d, ninj[4];
	logic [11:0] rz[9] = '{slsync_pkg::ADDR_SYNC_MASK, slsync_pkg::ADDR_SYNC_DUR, slsync_pkg::ADDR_PHY_SETUP,
		slsync_pkg::ADDR_TEST_EN, slsync_pkg::ADDR_TEST_CTRL, slsync_pkg::ADDR_THR_LO, slsync_pkg::ADDR_THR_MID,
		slsync_pkg::ADDR_THR_HI, slsync_pkg::ADDR_CNT_LO};
	slsync_core u_dut (.mclk(mclk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
		.regRd(regRd), .regRdata(regRdata), .fifoEmpty(fifoEmpty), .frameLoss(frameLoss),
		.multiframeLoss(multiframeLoss), .multiframePeriodCycles(mfp), .laneBits(laneBits),
		.syncRequestOut_n(syncRequestOut_n), .lanePhySetupValue(setup));
	slsync_tx_model u_tx (.mclk(mclk), .rst_n(rst_n), .patSel(pat), .flip(flip), .laneBits(laneBits));
	// ----------------
	// clock, timeout, report
	// ----------------
	initial forever #25 mclk = ~mclk;
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 40000) begin
			err_count++;
			complete_run();
		end
	end
	task complete_run;
		$display("mismatches %0d of %0d compares", err_count, n_compared);
		if (err_count == 0 && n_compared > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : complete_run
	task chk(input logic [23:0] got, input logic [23:0] exp);
		n_compared++;
		if (got !== exp) begin
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
			err_count++;
		end
	endtask : chk
	// ----------------
	// register port
	// ----------------
	task wr(input logic [11:0] ad, input logic [7:0] dt);
		@(posedge mclk) begin regAddr <= ad; regWdata <= dt; regWr <= 1; end
		@(posedge mclk) regWr <= 0;
	endtask : wr
	task rd(input logic [11:0] ad, output logic [7:0] dt);
		@(posedge mclk) begin regAddr <= ad; regRd <= 1; end
		@(posedge mclk) regRd <= 0;
		@(posedge mclk) dt = regRdata;
	endtask : rd
	task setctl(input logic [7:0] c);
		ctl = c;
		wr(slsync_pkg::ADDR_TEST_CTRL, c);
	endtask : setctl
	// counts read while no errors arrive, since the bytes are live
	task readall(output logic [23:0] c[4]);
		for (int i = 0; i < 4; i++) begin
			setctl({1'b0, 3'(i), ctl[3:0]});
			rd(slsync_pkg::ADDR_CNT_LO, c[i][7:0]);
			rd(slsync_pkg::ADDR_CNT_MID, c[i][15:8]);
			rd(slsync_pkg::ADDR_CNT_HI, c[i][23:16]);
		end
	endtask : readall
	task inject(input int n);
		repeat (n) begin
			fl = 4'($urandom_range(1, 15));
			for (int i = 0; i < 4; i++) ninj[i] += fl[i];
			@(posedge mclk) flip <= fl;
			@(posedge mclk) flip <= 4'h0;
			repeat (40) @(posedge mclk);
		end
	endtask : inject
	// ----------------
	// main sequence
	// ----------------
	initial begin
		void'($urandom(63845));
		repeat (10) @(posedge mclk);
		rst_n <= 1;
		foreach (rz[i]) begin
			rd(rz[i], v);
			chk(v, 8'h00);
		end
		// threshold and counts both reset to zero, so no lane is below it
		rd(slsync_pkg::ADDR_PASS, v);
		chk(v, 8'h00);
		fifoEmpty <= 4'($urandom());
		mfp <= 8'($urandom());
		repeat (4) @(posedge mclk);
		rd(slsync_pkg::ADDR_FIFO_EMPTY, v);
		chk(v, {4'h0, fifoEmpty});
		rd(slsync_pkg::ADDR_MF_PERIOD, v);
		chk(v, mfp);
		wr(slsync_pkg::ADDR_PHY_SETUP, 8'h01);
		@(posedge mclk) chk(setup, 8'h01);
		wr(slsync_pkg::ADDR_SYNC_MASK, 8'hFF);
		rd(slsync_pkg::ADDR_SYNC_MASK, v);
		chk(v, 8'h05);
		wr(slsync_pkg::ADDR_TEST_EN, 8'hFF);
		rd(slsync_pkg::ADDR_TEST_EN, v);
		chk(v, 8'h0F);
		wr(12'h300, 8'hFF);
		rd(12'h300, v);
		chk(v, 8'h00);
		// loss kind against mask bit; only the matching pair pulls the request low
		for (int k = 0; k < 4; k++) begin
			d = $urandom_range(0, 15);
			wr(slsync_pkg::ADDR_SYNC_MASK, k[0] ? 8'h01 : 8'h04);
			wr(slsync_pkg::ADDR_SYNC_DUR, 8'(d));
			@(posedge mclk) if (k[1]) multiframeLoss <= 1; else frameLoss <= 1;
			@(posedge mclk) begin multiframeLoss <= 0; frameLoss <= 0; end
			w = 0;
			repeat (40) @(posedge mclk) if (syncRequestOut_n === 1'b0) w++;
			if (k[0] ^ k[1]) chk(24'(w >= 9 + d && w <= 13 + d), 24'h1);
			else chk(24'(w), 24'h0);
		end
		// lane 3 left disabled so its count must not move
		wr(slsync_pkg::ADDR_TEST_EN, 8'h07);
		for (int p = 0; p < 4; p++) begin
			pat <= 2'(p);
			setctl({4'h0, 2'(p), 2'h3});
			readall(a);
			chk(a[0], 24'h0);
			setctl({4'h0, 2'(p), 2'h2});
			repeat (40) @(posedge mclk);
			readall(a);
			ninj = '{0, 0, 0, 0};
			inject(3);
			readall(b);
			for (int i = 0; i < 4; i++) chk(b[i] - a[i], (p == 3 || i == 3) ? 24'h0 : 24'(3 * ninj[i]));
		end
		pat <= 2'h0;
		setctl(8'h00);
		readall(a);
		inject(2);
		readall(b);
		for (int i = 0; i < 4; i++) chk(b[i], a[i]);
		setctl(8'h02);
		repeat (40) @(posedge mclk);
		readall(a);
		thr = a[0] + 24'h3;
		wr(slsync_pkg::ADDR_THR_LO, thr[7:0]);
		wr(slsync_pkg::ADDR_THR_MID, thr[15:8]);
		wr(slsync_pkg::ADDR_THR_HI, thr[23:16]);
		@(posedge mclk) flip <= 4'h1;
		@(posedge mclk) flip <= 4'h0;
		repeat (40) @(posedge mclk);
		readall(b);
		rd(slsync_pkg::ADDR_PASS, v);
		chk(v, {4'h0, b[3] < thr, b[2] < thr, b[1] < thr, b[0] < thr});
		rd(slsync_pkg::ADDR_THR_MID, v);
		chk(v, thr[15:8]);
		rd(slsync_pkg::ADDR_THR_HI, v);
		chk(v, thr[23:16]);
		// source select beyond the four lanes reads zero
		setctl(8'h52);
		rd(slsync_pkg::ADDR_CNT_LO, v);
		chk(v, 8'h00);
		complete_run();
	end
endmodule : tb
